//--- hdl/ebc_bus_ctrl.sv
// external bus control strobes, hold, flag and aux pins
`timescale 1ns/1ps
module ebc_bus_ctrl #(
  parameter int AW = ebc_pkg::EBC_AW,
  parameter int DW = ebc_pkg::EBC_DW,
  parameter int AUX_N = ebc_pkg::EBC_AUX_N
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // core access request
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic req_write_i,
  input wire ebc_pkg::ebc_space_t req_space_i,
  input wire logic [AW-1:0] req_addr_i,
  input wire logic [DW-1:0] req_wdata_i,
  output logic rsp_valid_o,
  output logic [DW-1:0] rsp_rdata_o,
  // core flag, branch, hold mode and aux control
  input wire logic flag_we_i,
  input wire logic flag_val_i,
  input wire logic branch_poll_i,
  output logic branch_take_o,
  input wire logic hold_mode_we_i,
  input wire logic hold_mode_val_i,
  output logic hold_mode_o,
  input wire logic aux_we_i,
  input wire logic [AUX_N-1:0] aux_dir_i,
  input wire logic [AUX_N-1:0] aux_val_i,
  output logic [AUX_N-1:0] aux_in_o,
  // pins in
  input wire logic ready_i,
  input wire logic float_all_n_i,
  input wire logic hold_req_n_i,
  input wire logic branch_condition_in_i,
  input wire logic [DW-1:0] data_i,
  input wire logic [AUX_N-1:0] aux_io_pins_i,
  // address and data pins out
  output logic [AW-1:0] addr_o,
  output logic addr_oe_o,
  output logic [DW-1:0] data_o,
  output logic data_oe_o,
  // control pins out
  output logic program_space_select_n_o,
  output logic data_space_select_n_o,
  output logic io_space_select_n_o,
  output logic bus_cycle_strobe_n_o,
  output logic read_dir_o,
  output logic read_strobe_n_o,
  output logic write_strobe_n_o,
  output logic global_bus_request_n_o,
  output logic hold_grant_n_o,
  output logic external_flag_out_o,
  output logic ctrl_oe_o,
  output logic mem_ctrl_oe_o,
  output logic [AUX_N-1:0] aux_io_pins_o,
  output logic [AUX_N-1:0] aux_io_pins_oe_o
);
  localparam int SW = 4 + AUX_N;

  typedef struct packed {
    ebc_pkg::ebc_state_t fsm;
    logic wr;
    ebc_pkg::ebc_space_t space;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;
    logic rvalid;
    logic brtake;
    logic flag;
    logic hold_mode;
    logic [AUX_N-1:0] aux_dir;
    logic [AUX_N-1:0] aux_val;
  } ebc_st_t;

  ebc_st_t st;
  ebc_st_t next_st;
  logic [SW-1:0] sync_in;
  logic [SW-1:0] sync_out;
  logic ready_s;
  logic float_n_s;
  logic hold_n_s;
  logic bio_s;
  logic [AUX_N-1:0] aux_s;
  logic floating;
  logic in_cycle;
  logic in_idle;
  logic in_hold;
  logic hold_pend;
  logic wr_cyc;
  logic rd_cyc;

  // decode a space to one-hot selects: prog, data, io
  function automatic logic [2:0] space_sel(input ebc_pkg::ebc_space_t sp);
    case (sp)
      ebc_pkg::EBC_SP_PROG: space_sel = 3'b001;
      ebc_pkg::EBC_SP_DATA: space_sel = 3'b010;
      ebc_pkg::EBC_SP_GLOBAL: space_sel = 3'b010;
      ebc_pkg::EBC_SP_IO: space_sel = 3'b100;
      default: space_sel = 3'b000;
    endcase
  endfunction

  // global data space flag
  function automatic logic is_global(input ebc_pkg::ebc_space_t sp);
    is_global = (sp == ebc_pkg::EBC_SP_GLOBAL);
  endfunction

  // pin synchronisers
  assign sync_in = {ready_i, float_all_n_i, hold_req_n_i,
                    branch_condition_in_i, aux_io_pins_i};
  ebc_sync #(
    .W(SW)
  ) u_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(sync_in),
    .q_o(sync_out)
  );
  assign {ready_s, float_n_s, hold_n_s, bio_s, aux_s} = sync_out;

  always_comb begin
    next_st = st;
    next_st.rvalid = 1'b0;
    next_st.brtake = 1'b0;
    if (branch_poll_i) begin
      next_st.brtake = !bio_s;
    end
    if (flag_we_i) begin
      next_st.flag = flag_val_i;
    end
    if (hold_mode_we_i) begin
      next_st.hold_mode = hold_mode_val_i;
    end
    if (aux_we_i) begin
      next_st.aux_dir = aux_dir_i;
      next_st.aux_val = aux_val_i;
    end
    case (st.fsm)
      ebc_pkg::EBC_ST_IDLE: begin
        if (hold_pend) begin
          next_st.fsm = ebc_pkg::EBC_ST_HOLD;
        end else if (req_valid_i) begin
          next_st.fsm = ebc_pkg::EBC_ST_ADDR;
          next_st.wr = req_write_i;
          next_st.space = req_space_i;
          next_st.addr = req_addr_i;
          next_st.wdata = req_wdata_i;
        end
      end
      ebc_pkg::EBC_ST_ADDR: begin
        next_st.fsm = ebc_pkg::EBC_ST_WAIT;
      end
      ebc_pkg::EBC_ST_WAIT: begin
        if (ready_s) begin
          next_st.fsm = ebc_pkg::EBC_ST_DONE;
          // read word is stable under our own read strobe
          next_st.rdata = st.wr ? st.rdata : data_i;
          next_st.rvalid = 1'b1;
        end
      end
      ebc_pkg::EBC_ST_DONE: begin
        next_st.fsm = ebc_pkg::EBC_ST_IDLE;
      end
      ebc_pkg::EBC_ST_HOLD: begin
        if (hold_n_s) begin
          next_st.fsm = ebc_pkg::EBC_ST_IDLE;
        end
      end
      default: begin
        next_st.fsm = ebc_pkg::EBC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      st.fsm <= ebc_pkg::EBC_ST_IDLE;
      st.wr <= 1'b0;
      st.space <= ebc_pkg::EBC_SP_PROG;
      st.addr <= '0;
      st.wdata <= '0;
      st.rdata <= '0;
      st.rvalid <= 1'b0;
      st.brtake <= 1'b0;
      st.flag <= ebc_pkg::EBC_FLAG_RST;
      st.hold_mode <= ebc_pkg::EBC_HOLD_MODE_RST;
      st.aux_dir <= AUX_N'(ebc_pkg::EBC_AUX_DIR_RST);
      st.aux_val <= AUX_N'(ebc_pkg::EBC_AUX_VAL_RST);
    end else begin
      st <= next_st;
    end
  end

  assign floating = !float_n_s;
  assign in_cycle = (st.fsm == ebc_pkg::EBC_ST_WAIT);
  assign in_idle = (st.fsm == ebc_pkg::EBC_ST_IDLE);
  assign in_hold = (st.fsm == ebc_pkg::EBC_ST_HOLD);
  assign hold_pend = !hold_n_s && !st.hold_mode;
  assign wr_cyc = in_cycle && st.wr;
  assign rd_cyc = in_cycle && !st.wr;

  // core side
  assign req_ready_o = in_idle && !hold_pend;
  assign rsp_valid_o = st.rvalid;
  assign rsp_rdata_o = st.rdata;
  assign branch_take_o = st.brtake;
  assign hold_mode_o = st.hold_mode;
  assign aux_in_o = aux_s;

  // pins: address, data
  assign addr_o = st.addr;
  assign addr_oe_o = floating ? 1'b0 : !in_hold;
  assign data_o = st.wdata;
  assign data_oe_o = rst_n_i && !floating && wr_cyc;

  // pins: control
  always_comb begin
    logic [2:0] sel;
    sel = 3'b000;
    if (in_cycle && !is_global(st.space)) begin
      sel = space_sel(st.space);
    end
    program_space_select_n_o = !sel[0];
    data_space_select_n_o = !sel[1];
    io_space_select_n_o = !sel[2];
    bus_cycle_strobe_n_o = !in_cycle;
    read_dir_o = !wr_cyc;
    read_strobe_n_o = !rd_cyc;
    write_strobe_n_o = !wr_cyc;
    global_bus_request_n_o = !(in_cycle && is_global(st.space));
  end
  assign hold_grant_n_o = !in_hold;
  assign external_flag_out_o = st.flag;
  // grant, flag and request stay driven in hold
  assign ctrl_oe_o = !floating;
  // memory strobes, selects and direction float in hold
  assign mem_ctrl_oe_o = !floating && !in_hold;

  // aux pins
  for (genvar g = 0; g < AUX_N; g++) begin : g_aux
    assign aux_io_pins_o[g] = st.aux_val[g];
    assign aux_io_pins_oe_o[g] = !floating && st.aux_dir[g];
  end
endmodule

//--- hdl/ebc_pkg.sv
// package for the external bus control block
package ebc_pkg;
  // access spaces
  typedef enum logic [1:0] {
    EBC_SP_PROG = 2'b00,
    EBC_SP_DATA = 2'b01,
    EBC_SP_IO = 2'b10,
    EBC_SP_GLOBAL = 2'b11
  } ebc_space_t;

  // bus cycle states
  typedef enum logic [2:0] {
    EBC_ST_IDLE = 3'b000,
    EBC_ST_ADDR = 3'b001,
    EBC_ST_WAIT = 3'b010,
    EBC_ST_DONE = 3'b011,
    EBC_ST_HOLD = 3'b100
  } ebc_state_t;

  localparam int EBC_AW = 16;
  localparam int EBC_DW = 16;
  localparam int EBC_AUX_N = 4;
  localparam logic EBC_FLAG_RST = 1'b0;
  localparam logic EBC_HOLD_MODE_RST = 1'b0;
  localparam logic [3:0] EBC_AUX_DIR_RST = 4'h0;
  localparam logic [3:0] EBC_AUX_VAL_RST = 4'h0;
endpackage

//--- hdl/ebc_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module ebc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ebc_sync_st_t;

  ebc_sync_st_t st;
  ebc_sync_st_t next_st;

  always_comb begin
    next_st = st;
    next_st.s1 = d_i;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      st <= '1;
    end else begin
      st <= next_st;
    end
  end

  assign q_o = st.s2;
endmodule

//--- testbench/ebc_bus_ctrl_chk.sv
// assertions on the bus control pins
`timescale 1ns/1ps
module ebc_chk (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // pins and core flag write in
  input wire logic ready_i,
  input wire logic float_all_n_i,
  input wire logic flag_we_i,
  // pins and core response valid out
  input wire logic program_space_select_n_o,
  input wire logic data_space_select_n_o,
  input wire logic io_space_select_n_o,
  input wire logic bus_cycle_strobe_n_o,
  input wire logic read_dir_o,
  input wire logic read_strobe_n_o,
  input wire logic write_strobe_n_o,
  input wire logic external_flag_out_o,
  input wire logic ctrl_oe_o,
  input wire logic mem_ctrl_oe_o,
  input wire logic addr_oe_o,
  input wire logic hold_grant_n_o,
  input wire logic data_oe_o,
  input wire logic rsp_valid_o
);
  wire [2:0] sel_n = {program_space_select_n_o, data_space_select_n_o,
    io_space_select_n_o};
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_busy; !bus_cycle_strobe_n_o; endsequence
  sequence s_stall; !ready_i [*4] ##0 s_busy; endsequence
  property p_sel; !(&sel_n) |-> s_busy; endproperty
  a_sel: assert property (p_sel) else $error("select off cycle");
  property p_one; s_busy |-> $countones(sel_n) >= 2; endproperty
  a_one: assert property (p_one) else $error("two selects");
  property p_rd; !read_strobe_n_o |-> read_dir_o ##0 s_busy; endproperty
  a_rd: assert property (p_rd) else $error("read strobe");
  property p_wr; !write_strobe_n_o |-> !read_dir_o && data_oe_o; endproperty
  a_wr: assert property (p_wr) else $error("write strobe");
  property p_stall; s_stall |=> s_busy; endproperty
  a_stall: assert property (p_stall) else $error("no wait");
  property p_rsp;
    rsp_valid_o |-> !$past(bus_cycle_strobe_n_o) && bus_cycle_strobe_n_o;
  endproperty
  a_rsp: assert property (p_rsp) else $error("cycle strobe");
  property p_flt;
    !float_all_n_i [*4] |-> !ctrl_oe_o && !mem_ctrl_oe_o && !data_oe_o;
  endproperty
  a_flt: assert property (p_flt) else $error("float");
  property p_hold;
    !hold_grant_n_o |-> !mem_ctrl_oe_o && !addr_oe_o && !data_oe_o &&
      bus_cycle_strobe_n_o;
  endproperty
  a_hold: assert property (p_hold) else $error("hold float");
  property p_flag; !flag_we_i |=> $stable(external_flag_out_o); endproperty
  a_flag: assert property (p_flag) else $error("flag moved");
endmodule
bind ebc_bus_ctrl ebc_chk ebc_chk_i (.*);

//--- testbench/ebc_mem.sv
// far-side memory answering the device strobes
`timescale 1ns/1ps
module ebc_mem (
  // bus from the device
  input wire logic [15:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic read_strobe_n_i,
  input wire logic write_strobe_n_i,
  // data toward the device
  output logic [15:0] rdata_o
);
  logic [15:0] mem [16] = '{default: 16'h0000};
  always @(posedge write_strobe_n_i) mem[addr_i[3:0]] <= wdata_i;
  assign rdata_o = mem[addr_i[3:0]] ^ {16{read_strobe_n_i}};
endmodule

//--- testbench/external_bus_control_strobes_tb_top.sv
// self-checking bench for the bus control block
`timescale 1ns/1ps
`define CK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
  $display("BAD %0t %h %h", $time, (a), (b)); end end
module external_bus_control_strobes_tb_top;
  logic core_clk_i = 0, rst_n_i = 0, req_valid_i = 0, req_write_i = 0;
  logic flag_we_i = 0, flag_val_i = 0, branch_poll_i = 0, aux_we_i = 0;
  logic ready_i = 1, float_all_n_i = 1, hold_req_n_i = 1;
  logic branch_condition_in_i = 1, hold_mode_we_i = 0, hold_mode_val_i = 0;
  ebc_pkg::ebc_space_t req_space_i = ebc_pkg::EBC_SP_PROG;
  logic [15:0] req_addr_i = '0, req_wdata_i = '0, data_i, addr_o, data_o;
  logic [15:0] rsp_rdata_o, exp_mem [16] = '{default: 16'h0000};
  logic [3:0] aux_dir_i = '0, aux_val_i = '0, aux_io_pins_i = '0;
  logic [3:0] aux_in_o, aux_io_pins_o, aux_io_pins_oe_o;
  logic req_ready_o, rsp_valid_o, branch_take_o, hold_mode_o, addr_oe_o;
  logic data_oe_o, program_space_select_n_o, data_space_select_n_o;
  logic io_space_select_n_o, bus_cycle_strobe_n_o, read_dir_o, ctrl_oe_o;
  logic read_strobe_n_o, write_strobe_n_o, global_bus_request_n_o;
  logic hold_grant_n_o, external_flag_out_o, mem_ctrl_oe_o;
  logic [31:0] seed = 32'h0001_5F62, r;
  int error_cnt = 0, n_compared = 0;
  wire [3:0] sels = {program_space_select_n_o, data_space_select_n_o,
    io_space_select_n_o, global_bus_request_n_o};
  wire [3:0] ctl = {read_dir_o, read_strobe_n_o, write_strobe_n_o, data_oe_o};
  ebc_bus_ctrl ebc_bus_ctrl_i (.*);
  ebc_mem ebc_mem_i (.addr_i(addr_o), .wdata_i(data_o),
    .read_strobe_n_i(read_strobe_n_o), .write_strobe_n_i(write_strobe_n_o),
    .rdata_o(data_i));
  initial forever #5 core_clk_i = ~core_clk_i;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [3:0] sel_of(ebc_pkg::ebc_space_t s);
    case (s)
      ebc_pkg::EBC_SP_PROG: return 4'h7;
      ebc_pkg::EBC_SP_DATA: return 4'hB;
      ebc_pkg::EBC_SP_IO: return 4'hD;
      default: return 4'hE;
    endcase
  endfunction
  task automatic tick();
    @(posedge core_clk_i);
    #1;
  endtask
  task automatic conclude();
    if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic acc(input logic w, input ebc_pkg::ebc_space_t s,
    input logic [3:0] a, input int wt, input logic [15:0] d);
    int n;
    req_valid_i = 1'b1;
    req_write_i = w;
    req_space_i = s;
    ready_i = (wt == 0);
    req_addr_i = {12'h000, a};
    req_wdata_i = d;
    for (n = 0; req_ready_o !== 1'b1 && n < 20; n++) tick();
    tick();
    req_valid_i = 0;
    for (n = 0; bus_cycle_strobe_n_o !== 1'b0 && n < 20; n++) tick();
    `CK(sels, sel_of(s))
    `CK(addr_o, {12'h000, a})
    `CK(ctl, {!w, w, !w, w})
    if (w) `CK(data_o, d)
    repeat (wt) begin
      tick();
      `CK({bus_cycle_strobe_n_o, rsp_valid_o}, 2'b00)
    end
    ready_i = 1;
    for (n = 1; rsp_valid_o !== 1'b1 && n < 20; n++) tick();
    `CK(rsp_valid_o, 1'b1)
    if (wt == 0) `CK(n, 2)
    if (!w) `CK(rsp_rdata_o, exp_mem[a])
    else exp_mem[a] = d;
  endtask
  initial begin
    repeat (12) tick();
    `CK({external_flag_out_o, hold_mode_o, aux_io_pins_oe_o, sels, ctl},
      14'h00FE)
    rst_n_i = 1;
    for (int i = 0; i < 48; i++) begin
      r = rnd();
      aux_io_pins_i = r[15:12];
      acc(i < 8 ? i[0] : r[0],
        ebc_pkg::ebc_space_t'(i < 8 ? i[2:1] : r[2:1]),
        i < 8 ? 4'hF : r[6:3], int'(r[8:7]), r[31:16]);
      `CK(aux_in_o, aux_io_pins_i)
    end
    {flag_we_i, flag_val_i} = 2'b11;
    tick();
    {flag_we_i, flag_val_i} = 2'b00;
    repeat (2) tick();
    `CK(external_flag_out_o, 1'b1)
    for (int v = 0; v < 2; v++) begin
      branch_condition_in_i = v[0];
      repeat (3) tick();
      branch_poll_i = 1;
      tick();
      branch_poll_i = 0;
      `CK(branch_take_o, !v[0])
    end
    r = rnd();
    {aux_we_i, aux_dir_i, aux_val_i} = {1'b1, r[3:0], r[7:4]};
    tick();
    aux_we_i = 0;
    `CK({aux_io_pins_oe_o, aux_io_pins_o}, {r[3:0], r[7:4]})
    float_all_n_i = 0;
    repeat (4) tick();
    `CK({ctrl_oe_o, mem_ctrl_oe_o, addr_oe_o, data_oe_o, aux_io_pins_oe_o},
      8'h00)
    float_all_n_i = 1;
    {hold_mode_we_i, hold_mode_val_i, hold_req_n_i} = 3'b110;
    tick();
    hold_mode_we_i = 0;
    repeat (4) tick();
    `CK({hold_mode_o, hold_grant_n_o, req_ready_o}, 3'h7)
    {hold_mode_we_i, hold_mode_val_i} = 2'b10;
    tick();
    hold_mode_we_i = 0;
    repeat (2) tick();
    `CK({hold_grant_n_o, addr_oe_o, req_ready_o, mem_ctrl_oe_o, ctrl_oe_o},
      5'h01)
    hold_req_n_i = 1;
    acc(1'b0, ebc_pkg::EBC_SP_IO, 4'hF, 1, 16'h0000);
    conclude();
  end
  initial begin
    #20us;
    error_cnt++;
    conclude();
  end
endmodule
